// [logic/msbc_bal_reg.sv]
// Purpose: One 8-bit balance switch register and its any-set flag
// Assumes: Write strobe is one cycle on clk_sys
// Notes: Drives eight balance outputs directly
`timescale 1ns/1ns
module msbc_bal_reg (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Write
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Outputs
  output logic [7:0] bal_r,
  output logic any_r
);
  import msbc_pkg::*;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bal_r <= MSBC_RESET_VAL;
      any_r <= 1'b0;
    end else if (wr_en) begin
      bal_r <= wr_data;
      any_r <= |wr_data;
    end
  end
endmodule

// [logic/msbc_pkg.sv]
// Purpose: Shared constants for measure status and balance control
// Assumes: 8-bit registers on a byte address bus
// Notes: Offsets are byte addresses
package msbc_pkg;
  localparam int MSBC_AW = 7;
  localparam int MSBC_DW = 8;
  localparam logic [6:0] MSBC_CELL_CTRL = 7'h06;
  localparam logic [6:0] MSBC_TEMP_CTRL = 7'h07;
  localparam logic [6:0] MSBC_REG_CTRL = 7'h08;
  localparam logic [6:0] MSBC_PIN_CTRL = 7'h09;
  localparam logic [6:0] MSBC_STATUS = 7'h0a;
  localparam logic [6:0] MSBC_CELL_PROG_LO = 7'h0b;
  localparam logic [6:0] MSBC_CELL_PROG_HI = 7'h0c;
  localparam logic [6:0] MSBC_TEMP_PROG = 7'h0d;
  localparam logic [6:0] MSBC_BAL_LO = 7'h0e;
  localparam logic [6:0] MSBC_BAL_HI = 7'h0f;
  localparam int MSBC_START_BIT = 7;
  localparam logic [7:0] MSBC_RESET_VAL = 8'h00;
  localparam int MSBC_NCELL = 16;
  localparam int MSBC_NTEMP = 4;
  localparam int MSBC_CONV_CYCLES = 50;
  typedef enum logic [2:0] {
    MSBC_IDLE = 3'b000,
    MSBC_CELL = 3'b001,
    MSBC_TEMP = 3'b010,
    MSBC_REGV = 3'b011,
    MSBC_PIN = 3'b100
  } msbc_mode_e;
endpackage

// [logic/msbc_top.sv]
// Purpose: Measurement start/stop, exclusion, progress status, cell balance
// Assumes: Register port byte-wide; converter step is a fixed cycle count
// Notes: Each channel conversion takes CONV_CYCLES cycles, MSBC_CONV_CYCLES by default
//
// Contract
// [R1] Clearing regulator start never aborts conversion
// [R2] Regulator start ignored while other measurement runs
// [R3] Pin fault start bit at 09H starts detection
// [R4] Pin fault stop after current cell; bit busy
// [R5] Pin fault start ignored while other measurement runs
// [R6] Status register read-only, writes discarded
// [R7] Status bits 0-3 mirror the four busy flags
// [R8] Status bit 4 any lower balance active
// [R9] Status bit 5 any upper balance active
// [R10] Status bit 6 mirrors regulator drop detector
// [R11] Cell start clears progress, sets per cell
// [R12] Pin fault start clears progress, sets per cell
// [R13] 0BH cells 1-8, 0CH cells 9-16
// [R14] Temperature start clears sensor progress, sets per sensor
// [R15] 0EH bit n-1 drives balance output n
// [R16] 0FH drives outputs 9-16, any combination
// [R17] Cell start/stop at 06H top bit, busy
// [R18] Temperature start/stop at 07H top bit, busy
// [R19] Regulator start at 08H top bit
// [R20] One start at a time, fixed priority
`timescale 1ns/1ns
module msbc_top #(
  parameter int CONV_CYCLES = msbc_pkg::MSBC_CONV_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [msbc_pkg::MSBC_AW-1:0] reg_addr,
  input wire logic [msbc_pkg::MSBC_DW-1:0] reg_wdata,
  output logic [msbc_pkg::MSBC_DW-1:0] reg_rdata,
  output logic reg_rvalid,
  // Analog status
  input wire logic regulator_drop_flag,
  // Converter control
  output logic conv_start,
  output logic [2:0] conv_mode,
  output logic [3:0] conv_chan,
  // Balance outputs
  output logic [15:0] balance_output
);
  import msbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and synchroniser
  logic wr_cell, wr_temp, wr_reg, wr_pin, wr_bl, wr_bh;
  logic st_bit;
  logic drop_s1_r, drop_s2_r;
  assign st_bit = reg_wdata[MSBC_START_BIT];
  assign wr_cell = reg_wr && reg_addr == MSBC_CELL_CTRL;
  assign wr_temp = reg_wr && reg_addr == MSBC_TEMP_CTRL;
  assign wr_reg = reg_wr && reg_addr == MSBC_REG_CTRL;
  assign wr_pin = reg_wr && reg_addr == MSBC_PIN_CTRL;
  assign wr_bl = reg_wr && reg_addr == MSBC_BAL_LO;
  assign wr_bh = reg_wr && reg_addr == MSBC_BAL_HI;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      drop_s1_r <= 1'b0;
      drop_s2_r <= 1'b0;
    end else begin
      drop_s1_r <= regulator_drop_flag;
      drop_s2_r <= drop_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer
  msbc_mode_e mode_r;
  logic [3:0] idx_r;
  logic [3:0] last_r;
  logic [15:0] cnt_r;
  logic stop_r;
  logic [15:0] cell_prog_r;
  logic [3:0] temp_prog_r;
  logic [4:0] cell_cfg_r;
  logic [2:0] temp_cfg_r;
  logic idle, step_done;
  logic go_cell, go_temp, go_reg, go_pin;
  assign idle = mode_r == MSBC_IDLE;
  assign step_done = !idle && cnt_r == 16'(CONV_CYCLES - 1);
  // Start writes only take effect from idle; priority cell, temp, regulator, pin
  assign go_cell = idle && wr_cell && st_bit; // [R17] [R20]
  assign go_temp = idle && wr_temp && st_bit && !go_cell; // [R18] [R20]
  assign go_reg = idle && wr_reg && st_bit && !go_cell && !go_temp; // [R2] [R19] [R20]
  assign go_pin = idle && wr_pin && st_bit && !go_cell && !go_temp && !go_reg; // [R3] [R5] [R20]

  // Mode settings change only while idle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cell_cfg_r <= 5'h00;
      temp_cfg_r <= 3'h0;
    end else begin
      if (wr_cell && idle) begin
        cell_cfg_r <= reg_wdata[4:0];
      end
      if (wr_temp && idle) begin
        temp_cfg_r <= {reg_wdata[4], reg_wdata[1:0]};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode_r <= MSBC_IDLE;
      idx_r <= 4'h0;
      last_r <= 4'h0;
      cnt_r <= 16'h0000;
    end else if (go_cell) begin
      mode_r <= MSBC_CELL;
      cnt_r <= 16'h0000;
      idx_r <= reg_wdata[4] ? 4'h0 : reg_wdata[3:0];
      last_r <= reg_wdata[3:0];
    end else if (go_pin) begin
      mode_r <= MSBC_PIN;
      cnt_r <= 16'h0000;
      idx_r <= cell_cfg_r[4] ? 4'h0 : cell_cfg_r[3:0];
      last_r <= cell_cfg_r[3:0];
    end else if (go_temp) begin
      mode_r <= MSBC_TEMP;
      cnt_r <= 16'h0000;
      idx_r <= reg_wdata[4] ? 4'h0 : {2'b00, reg_wdata[1:0]};
      last_r <= {2'b00, reg_wdata[1:0]};
    end else if (go_reg) begin
      mode_r <= MSBC_REGV;
      cnt_r <= 16'h0000;
      idx_r <= 4'h0;
      last_r <= 4'h0;
    end else if (step_done) begin
      cnt_r <= 16'h0000;
      // Stop request honoured only at a channel boundary
      if (idx_r == last_r || (stop_r && mode_r != MSBC_REGV)) begin // [R4] [R1]
        mode_r <= MSBC_IDLE;
      end else begin
        idx_r <= idx_r + 4'h1;
      end
    end else if (!idle) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Pending stop; regulator control has no stop
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stop_r <= 1'b0;
    end else if (idle) begin
      stop_r <= 1'b0;
    end else begin
      case (mode_r)
        MSBC_CELL: begin
          if (wr_cell && !st_bit) stop_r <= 1'b1; // [R17]
        end
        MSBC_TEMP: begin
          if (wr_temp && !st_bit) stop_r <= 1'b1; // [R18]
        end
        MSBC_PIN: begin
          if (wr_pin && !st_bit) stop_r <= 1'b1; // [R4]
        end
        default: begin
          stop_r <= stop_r; // [R1]
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Progress registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cell_prog_r <= 16'h0000;
    end else if (go_cell || go_pin) begin
      cell_prog_r <= 16'h0000; // [R11] [R12]
    end else if (step_done && (mode_r == MSBC_CELL || mode_r == MSBC_PIN)) begin
      cell_prog_r[idx_r] <= 1'b1; // [R11] [R12] [R13]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      temp_prog_r <= 4'h0;
    end else if (go_temp) begin
      temp_prog_r <= 4'h0; // [R14]
    end else if (step_done && mode_r == MSBC_TEMP) begin
      temp_prog_r[idx_r[1:0]] <= 1'b1; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      conv_start <= 1'b0;
      conv_mode <= 3'b000;
      conv_chan <= 4'h0;
    end else begin
      conv_start <= !idle && cnt_r == 16'h0000;
      conv_mode <= mode_r;
      conv_chan <= idx_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Balance registers
  logic [7:0] bal_lo, bal_hi;
  logic any_lo, any_hi;
  msbc_bal_reg u_bal_lo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wr_en(wr_bl), // [R15]
    .wr_data(reg_wdata),
    .bal_r(bal_lo),
    .any_r(any_lo)
  );
  msbc_bal_reg u_bal_hi (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wr_en(wr_bh), // [R16]
    .wr_data(reg_wdata),
    .bal_r(bal_hi),
    .any_r(any_hi)
  );
  assign balance_output = {bal_hi, bal_lo}; // [R15] [R16]

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  logic b_cell, b_temp, b_reg, b_pin;
  logic [7:0] status;
  assign b_cell = mode_r == MSBC_CELL;
  assign b_temp = mode_r == MSBC_TEMP;
  assign b_reg = mode_r == MSBC_REGV;
  assign b_pin = mode_r == MSBC_PIN;
  // Status has no write decode at all
  assign status = {1'b0, drop_s2_r, any_hi, any_lo, b_pin, b_reg, b_temp, b_cell}; // [R6] [R7] [R8] [R9] [R10]

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= MSBC_RESET_VAL;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      case (reg_addr)
        MSBC_CELL_CTRL: reg_rdata <= {b_cell, 2'b00, cell_cfg_r};
        MSBC_TEMP_CTRL: reg_rdata <= {b_temp, 2'b00, temp_cfg_r[2], 2'b00, temp_cfg_r[1:0]};
        MSBC_REG_CTRL: reg_rdata <= {b_reg, 7'h00};
        MSBC_PIN_CTRL: reg_rdata <= {b_pin, 7'h00}; // [R4]
        MSBC_STATUS: reg_rdata <= status;
        MSBC_CELL_PROG_LO: reg_rdata <= cell_prog_r[7:0]; // [R13]
        MSBC_CELL_PROG_HI: reg_rdata <= cell_prog_r[15:8]; // [R13]
        MSBC_TEMP_PROG: reg_rdata <= {4'h0, temp_prog_r};
        MSBC_BAL_LO: reg_rdata <= bal_lo;
        MSBC_BAL_HI: reg_rdata <= bal_hi;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  regv_no_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R1]
    (b_reg && !step_done) |=> b_reg)
    else $error("regulator conversion ended early");
  regv_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R2]
    (!idle && wr_reg && st_bit && !b_reg) |=> !b_reg)
    else $error("regulator start accepted while busy");
  pin_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R3]
    go_pin |=> b_pin && cell_prog_r == 16'h0000)
    else $error("pin fault start not taken");
  pin_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R4]
    (b_pin && !step_done) |=> b_pin)
    else $error("pin fault ended mid cell");
  pin_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R5]
    (!idle && !b_pin && wr_pin) |=> !b_pin)
    else $error("pin fault start accepted while busy");
  status_ro_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R6]
    (reg_wr && reg_addr == MSBC_STATUS && idle) |=> $stable(bal_lo) && $stable(bal_hi)
    && $stable(mode_r) && $stable(cell_cfg_r) && $stable(temp_cfg_r))
    else $error("status write changed state");
  busy_onehot_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R7] [R20]
    $onehot0(status[3:0]) && (status[3:0] == 4'h0) == idle)
    else $error("busy flags inconsistent");
  bal_any_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R8] [R9]
    any_lo == (|bal_lo) && any_hi == (|bal_hi))
    else $error("balance flag mismatch");
  drop_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R10]
    status[6] == $past(regulator_drop_flag, 2))
    else $error("drop flag not mirrored");
  prog_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R11] [R13]
    (step_done && b_cell) |=> cell_prog_r[$past(idx_r)])
    else $error("cell progress bit not set");
  temp_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R14]
    (step_done && b_temp) |=> temp_prog_r[$past(idx_r[1:0])])
    else $error("sensor progress bit not set");
  temp_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R14] [R18]
    go_temp |=> temp_prog_r == 4'h0 && b_temp)
    else $error("temperature progress not cleared");
endmodule

// [testbench/msbc_host_model.sv]
// Purpose: Host side of the byte register port
// Assumes: One request at a time, launched on a rising edge
// Notes: Address, and on a write also data, are inverted once a request is released
`timescale 1ns/1ns
module msbc_host_model (
  // Clock
  input wire logic clk_sys,
  // Request
  output logic reg_wr,
  output logic reg_rd,
  output logic [msbc_pkg::MSBC_AW-1:0] reg_addr,
  output logic [msbc_pkg::MSBC_DW-1:0] reg_wdata,
  // Answer
  input wire logic [msbc_pkg::MSBC_DW-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  import msbc_pkg::*;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    int n;
    d = 8'hxx;
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (n = 0; n < 4; n++) begin
      @(posedge clk_sys);
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
    end
  endtask
endmodule

// [testbench/test_measure_status_balance_ctrl.sv]
// Purpose: Self-checking bench for measure status and balance control
// Assumes: Conversion step shortened to 12 cycles
// Notes: All register traffic goes through the host model
`timescale 1ns/1ns
module test_measure_status_balance_ctrl;
  import msbc_pkg::*;
  logic clk_sys, rst_b, reg_wr, reg_rd, reg_rvalid, regulator_drop_flag, conv_start;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [2:0] conv_mode;
  logic [3:0] conv_chan;
  logic [15:0] balance_output;
  int errors, check_count, starts;
  logic [6:0] last_conv;
  ////////////////////////////////////////////////////////////////////////////////
  msbc_top #(.CONV_CYCLES(12)) msbc_top_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .regulator_drop_flag(regulator_drop_flag), .conv_start(conv_start),
    .conv_mode(conv_mode), .conv_chan(conv_chan), .balance_output(balance_output));
  msbc_host_model msbc_host_model_i (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (conv_start === 1'b1) begin
      starts++;
      last_conv = {conv_mode, conv_chan};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    msbc_host_model_i.rd(a, rv);
    if ($isunknown(rv)) begin
      errors++;
      $display("ERROR %0t no read answer", $time);
      conclude();
    end
    chk({8'h00, rv}, {8'h00, e});
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_idle(input logic [6:0] a);
    int n;
    for (n = 0; n < 200; n++) begin
      msbc_host_model_i.rd(a, rv);
      if (rv[7] === 1'b0) break;
    end
    if (rv[7] !== 1'b0) begin
      errors++;
      $display("ERROR %0t busy never cleared", $time);
      conclude();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    check_count = 0;
    starts = 0;
    rst_b = 1'b0;
    regulator_drop_flag = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 6; i < 16; i++) rchk(7'(i), 8'h00);
    msbc_host_model_i.wr(7'h0e, 8'ha5);
    rchk(7'h0a, 8'h10);
    chk(balance_output, 16'h00a5);
    msbc_host_model_i.wr(7'h0f, 8'h81);
    rchk(7'h0a, 8'h30);
    chk(balance_output, 16'h81a5);
    rchk(7'h0f, 8'h81);
    msbc_host_model_i.wr(7'h0e, 8'h00);
    rchk(7'h0a, 8'h20);
    msbc_host_model_i.wr(7'h0a, 8'hff);
    rchk(7'h0a, 8'h20);
    msbc_host_model_i.wr(7'h0f, 8'h00);
    rchk(7'h0a, 8'h00);
    chk(balance_output, 16'h0000);
    starts = 0;
    msbc_host_model_i.wr(7'h06, 8'h99);
    rchk(7'h0a, 8'h01);
    rchk(7'h06, 8'h99);
    msbc_host_model_i.wr(7'h08, 8'h80);
    msbc_host_model_i.wr(7'h09, 8'h80);
    msbc_host_model_i.wr(7'h07, 8'h93);
    rchk(7'h0a, 8'h01);
    wait_idle(7'h06);
    rchk(7'h0b, 8'hff);
    rchk(7'h0c, 8'h03);
    chk(16'(starts), 16'd10);
    chk(16'(last_conv), {9'h000, MSBC_CELL, 4'h9});
    rchk(7'h07, 8'h00);
    starts = 0;
    msbc_host_model_i.wr(7'h07, 8'h92);
    rchk(7'h0a, 8'h02);
    wait_idle(7'h07);
    rchk(7'h0d, 8'h07);
    chk(16'(starts), 16'd3);
    chk(16'(last_conv), {9'h000, MSBC_TEMP, 4'h2});
    msbc_host_model_i.wr(7'h07, 8'h81);
    wait_idle(7'h07);
    rchk(7'h0d, 8'h02);
    starts = 0;
    msbc_host_model_i.wr(7'h09, 8'h80);
    msbc_host_model_i.wr(7'h09, 8'h00);
    rchk(7'h09, 8'h80);
    rchk(7'h0a, 8'h08);
    wait_idle(7'h09);
    rchk(7'h0b, 8'h01);
    rchk(7'h0c, 8'h00);
    chk(16'(starts), 16'd1);
    chk(16'(last_conv), {9'h000, MSBC_PIN, 4'h0});
    starts = 0;
    msbc_host_model_i.wr(7'h08, 8'h80);
    msbc_host_model_i.wr(7'h09, 8'h80);
    msbc_host_model_i.wr(7'h06, 8'h80);
    msbc_host_model_i.wr(7'h08, 8'h00);
    rchk(7'h08, 8'h80);
    rchk(7'h0a, 8'h04);
    wait_idle(7'h08);
    chk(16'(starts), 16'd1);
    chk(16'(last_conv), {9'h000, MSBC_REGV, 4'h0});
    rchk(7'h06, 8'h19);
    msbc_host_model_i.wr(7'h06, 8'h8a);
    wait_idle(7'h06);
    rchk(7'h0b, 8'h00);
    rchk(7'h0c, 8'h04);
    @(posedge clk_sys);
    regulator_drop_flag <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rchk(7'h0a, 8'h40);
    @(posedge clk_sys);
    regulator_drop_flag <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rchk(7'h0a, 8'h00);
    rchk(7'h50, 8'h00);
    conclude();
  end
endmodule
